// file: design/data_space_defines.svh
// address map and timing constants for the data space decoder
`ifndef DATA_SPACE_DEFINES_SVH
`define DATA_SPACE_DEFINES_SVH
`define REGFILE_BASE        16'h0000
`define REGFILE_TOP         16'h001F
`define STD_IO_BASE         16'h0020
`define STD_IO_TOP          16'h005F
`define STD_IO_COUNT        7'h40
`define EXT_IO_BASE         16'h0060
`define EXT_IO_TOP          16'h00FF
`define EXT_IO_COUNT        8'hA0
`define INTERNAL_RAM_BASE   16'h0100
`define INTERNAL_RAM_TOP    16'h02FF
`define INTERNAL_RAM_BYTES  512
`define NVDATA_BYTES        512
`define NVDATA_TOP          16'h01FF
`define FLASH_BYTE_TOP      16'h3FFF
`define FLASH_WORD_TOP      16'h1FFF
`define DISP_MAX            6'h3F
`define PTR_X_LOW           5'h1A
`define PTR_Y_LOW           5'h1C
`define PTR_Z_LOW           5'h1E
`define RAM_ACCESS_CYCLES   2'h2
`endif

// file: design/data_space_pkg.sv
// types shared by the data space decoder files
package data_space_pkg;
    typedef enum logic [2:0] {
        MODE_DIRECT,
        MODE_DISP,
        MODE_INDIRECT,
        MODE_PREDEC,
        MODE_POSTINC
    } addr_mode_t;
    typedef enum logic [1:0] {
        PTR_X,
        PTR_Y,
        PTR_Z
    } ptr_sel_t;
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_REGFILE,
        TGT_STD_IO,
        TGT_EXT_IO,
        TGT_RAM
    } target_t;
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       shortIo;
        addr_mode_t mode;
        ptr_sel_t   ptr;
        logic [15:0] addr;
        logic [5:0] disp;
        logic [7:0] wdata;
    } data_req_t;
    typedef struct packed {
        logic       done;
        logic       refused;
        logic [7:0] rdata;
    } data_rsp_t;
endpackage

// file: design/internal_ram.sv
// internal data ram with two-cycle access
`timescale 1ns/1ns
`include "data_space_defines.svh"
module internal_ram #(
    parameter int BYTES = `INTERNAL_RAM_BYTES,
    parameter int AW    = 9
) (
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic          write,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic               done,
    output logic [7:0]         rdata
);
    typedef struct packed {
        logic       busy;
        logic       done;
        logic [7:0] rdata;
    } ram_state_t;
    logic [7:0] mem [BYTES];
    ram_state_t state;
    ram_state_t next_state;

    // first cycle takes the address, second returns data;
    // done stands with busy so the answer is in the second cycle
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (state.busy) begin
            next_state.busy = 1'b0;
        end else if (start) begin
            next_state.busy = 1'b1;
            next_state.done = 1'b1;
            if (!write) begin
                next_state.rdata = mem[addr];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // array has no reset, contents undefined after power up
    always_ff @(posedge ref_clk) begin
        if (start && write && !state.busy) begin
            mem[addr] <= wdata;
        end
    end

    assign done  = state.done;
    assign rdata = state.rdata;
endmodule

// file: design/data_space_decoder.sv
// data space decoder: map, addressing modes, pointers, ram timing
// Behaviour
// - addresses 0x00-0x1F hit register file
// - 0x20-0x5F hit standard io window
// - next 160 addresses hit extended io
// - 0x0100-0x02FF hit 512 byte ram
// - short io forms reach standard io only
// - five data addressing modes supported
// - direct mode reaches whole data space
// - displacement 0..63 on Y or Z only
// - predecrement before use, postincrement after, writeback
// - registers 26..31 form X, Y, Z
// - all regions reachable in every mode, except displacement on X, which is refused
// - ram access takes two clocks
// - flash is 16-bit words, top 0x1FFF
// - self program store allowed from anywhere
// - nonvolatile data is separate 512 bytes
// - working register at its own address
`timescale 1ns/1ns
`include "data_space_defines.svh"
module data_space_decoder #(
    parameter int RAM_BYTES  = `INTERNAL_RAM_BYTES,
    parameter int FLASH_AW   = 13,
    parameter int NVDATA_AW  = 9
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire data_space_pkg::data_req_t req,
    output data_space_pkg::data_rsp_t    rsp,
    output logic                         busy,
    // working register file port
    output logic [4:0]                   regAddr,
    output logic                         regWrite,
    output logic [7:0]                   regWdata,
    input  wire logic [7:0]              regRdata,
    // pointer pair writeback
    output logic                         ptrWrite,
    output logic [4:0]                   ptrLowAddr,
    output logic [15:0]                  ptrValue,
    input  wire logic [15:0]             ptrX,
    input  wire logic [15:0]             ptrY,
    input  wire logic [15:0]             ptrZ,
    // peripheral register banks
    output logic                         stdIoSel,
    output logic                         extIoSel,
    output logic [7:0]                   ioAddr,
    output logic                         ioWrite,
    output logic [7:0]                   ioWdata,
    input  wire logic [7:0]              ioRdata,
    // program space and nonvolatile data address checks
    input  wire logic [15:0]             progByteAddr,
    output logic [FLASH_AW-1:0]          progWordAddr,
    output logic                         progHighByte,
    output logic                         progInRange,
    output logic                         selfProgramAllowed,
    input  wire logic [15:0]             nvdataAddr,
    output logic                         nvdataInRange
);
    typedef struct packed {
        logic       ramWait;
        logic       done;
        logic       refused;
        logic [7:0] rdata;
    } dec_state_t;

    dec_state_t state;
    dec_state_t next_state;
    logic [15:0] base;
    logic [15:0] effAddr;
    logic [15:0] updated;
    data_space_pkg::target_t target;
    logic        ramStart;
    logic        ramDone;
    logic [7:0]  ramRdata;
    logic        badForm;

    // region decode used for both the access and the refusal check
    function automatic data_space_pkg::target_t decode(input logic [15:0] a);
        if (a <= `REGFILE_TOP) begin
            decode = data_space_pkg::TGT_REGFILE;
        end else if (a <= `STD_IO_TOP) begin
            decode = data_space_pkg::TGT_STD_IO;
        end else if (a <= `EXT_IO_TOP) begin
            decode = data_space_pkg::TGT_EXT_IO;
        end else if (a <= `INTERNAL_RAM_TOP) begin
            decode = data_space_pkg::TGT_RAM;
        end else begin
            decode = data_space_pkg::TGT_NONE;
        end
    endfunction

    // pointer pick from the pair registers 26..31
    always_comb begin
        unique case (req.ptr)
            data_space_pkg::PTR_X: begin
                base = ptrX;
                ptrLowAddr = `PTR_X_LOW;
            end
            data_space_pkg::PTR_Y: begin
                base = ptrY;
                ptrLowAddr = `PTR_Y_LOW;
            end
            default: begin
                base = ptrZ;
                ptrLowAddr = `PTR_Z_LOW;
            end
        endcase
    end

    // effective address per mode; every region open in every mode except displacement on X
    always_comb begin
        effAddr = req.addr;
        updated = base;
        badForm = 1'b0;
        ptrWrite = 1'b0;
        unique case (req.mode)
            data_space_pkg::MODE_DIRECT: begin
                effAddr = req.addr;
            end
            data_space_pkg::MODE_DISP: begin
                effAddr = base + {10'h000, req.disp};
                badForm = (req.ptr == data_space_pkg::PTR_X);
            end
            data_space_pkg::MODE_INDIRECT: begin
                effAddr = base;
            end
            data_space_pkg::MODE_PREDEC: begin
                updated = base - 16'h0001;
                effAddr = updated;
                ptrWrite = req.valid && !busy;
            end
            data_space_pkg::MODE_POSTINC: begin
                effAddr = base;
                updated = base + 16'h0001;
                ptrWrite = req.valid && !busy;
            end
            default: begin
                badForm = 1'b1;
            end
        endcase
        if (req.shortIo) begin
            // short forms carry a 6 bit io index only
            effAddr = `STD_IO_BASE + {10'h000, req.addr[5:0]};
        end
        if (badForm) begin
            ptrWrite = 1'b0;
        end
        ptrValue = updated;
    end

    assign target = badForm ? data_space_pkg::TGT_NONE : decode(effAddr);

    // one-cycle answer except ram, which stalls for its second cycle
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        next_state.refused = 1'b0;
        ramStart = 1'b0;
        if (state.ramWait) begin
            if (ramDone) begin
                next_state.ramWait = 1'b0;
                next_state.done = 1'b1;
                next_state.rdata = ramRdata;
            end
        end else if (req.valid) begin
            unique case (target)
                data_space_pkg::TGT_REGFILE: begin
                    next_state.done = 1'b1;
                    next_state.rdata = regRdata;
                end
                data_space_pkg::TGT_STD_IO,
                data_space_pkg::TGT_EXT_IO: begin
                    next_state.done = 1'b1;
                    next_state.rdata = ioRdata;
                end
                data_space_pkg::TGT_RAM: begin
                    ramStart = 1'b1;
                    next_state.ramWait = 1'b1;
                end
                default: begin
                    // unmapped: read zero, write dropped
                    next_state.done = 1'b1;
                    next_state.refused = 1'b1;
                    next_state.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // strobes to register file and io banks, gated by region
    always_comb begin
        regAddr  = effAddr[4:0];
        regWdata = req.wdata;
        regWrite = req.valid && !busy && req.write
                   && target == data_space_pkg::TGT_REGFILE;
        ioAddr   = 8'(effAddr - `STD_IO_BASE);
        ioWdata  = req.wdata;
        stdIoSel = req.valid && !busy && target == data_space_pkg::TGT_STD_IO;
        extIoSel = req.valid && !busy && target == data_space_pkg::TGT_EXT_IO;
        ioWrite  = req.write && (stdIoSel || extIoSel);
    end

    internal_ram #(
        .BYTES (RAM_BYTES),
        .AW    (9)
    ) ram (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (ramStart),
        .write   (req.write),
        .addr    (9'(effAddr - `INTERNAL_RAM_BASE)),
        .wdata   (req.wdata),
        .done    (ramDone),
        .rdata   (ramRdata)
    );

    // held request must stay until done while ram is busy
    assign busy = state.ramWait;
    assign rsp.done = state.done;
    assign rsp.refused = state.refused;
    assign rsp.rdata = state.rdata;

    // program space: 16-bit words, byte address bit 0 picks the half
    assign progWordAddr = progByteAddr[FLASH_AW:1];
    assign progHighByte = progByteAddr[0];
    assign progInRange  = progByteAddr <= `FLASH_BYTE_TOP;
    // no boot section, so no address limits the store instruction
    assign selfProgramAllowed = 1'b1;
    // separate space from zero; data and program decode never see it
    assign nvdataInRange = nvdataAddr <= `NVDATA_TOP;
endmodule

// file: bench/data_space_sva.sv
// assertion checker for the data space decoder ports
`timescale 1ns/1ns
module data_space_sva (
    input wire logic                      ref_clk,
    input wire logic                      rst,
    input wire data_space_pkg::data_req_t req,
    input wire data_space_pkg::data_rsp_t rsp,
    input wire logic                      busy,
    input wire logic [4:0]                regAddr,
    input wire logic                      regWrite,
    input wire logic                      ioWrite,
    input wire logic                      stdIoSel,
    input wire logic                      extIoSel,
    input wire logic [7:0]                ioAddr,
    input wire logic                      ptrWrite,
    input wire logic [4:0]                ptrLowAddr,
    input wire logic [15:0]               ptrValue,
    input wire logic [15:0]               ptrY
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic taken;
    logic direct;
    // a request only counts when the decoder is not stalled
    assign taken = req.valid && !busy;
    assign direct = taken && !req.shortIo && req.mode == data_space_pkg::MODE_DIRECT;

    a_reg_map: assert property (direct && req.addr <= 16'h001F |->
        regAddr == req.addr[4:0] ##1 rsp.done && !rsp.refused) else $error("register map");
    a_std_io: assert property (direct && req.addr inside {[16'h0020:16'h005F]} |->
        stdIoSel && !extIoSel && ioAddr == 8'(req.addr - 16'h0020)) else $error("std io map");
    a_ext_io: assert property (direct && req.addr inside {[16'h0060:16'h00FF]} |->
        extIoSel && !stdIoSel && ioAddr == 8'(req.addr - 16'h0020)) else $error("ext io map");
    a_short_io: assert property (taken && req.shortIo |-> stdIoSel && !extIoSel)
        else $error("short io reached ext io");
    a_ram_two: assert property (direct && req.addr inside {[16'h0100:16'h02FF]} |->
        ##1 busy && !rsp.done ##1 rsp.done && !rsp.refused) else $error("ram timing");
    a_unmapped: assert property (direct && req.addr > 16'h02FF |-> !regWrite && !ioWrite
        ##1 rsp.done && rsp.refused && rsp.rdata == 8'h00) else $error("unmapped access");
    a_post_inc: assert property (taken && !req.shortIo && req.ptr == data_space_pkg::PTR_Y
        && req.mode == data_space_pkg::MODE_POSTINC |-> ptrWrite && ptrLowAddr == 5'h1C
        && ptrValue == ptrY + 16'h0001) else $error("post increment");
    a_x_disp: assert property (taken && !req.shortIo && req.ptr == data_space_pkg::PTR_X
        && req.mode == data_space_pkg::MODE_DISP |-> ##1 rsp.refused) else $error("x disp");
endmodule
bind data_space_decoder data_space_sva chk (.ref_clk, .rst, .req, .rsp, .busy, .regAddr,
    .regWrite, .ioWrite, .stdIoSel, .extIoSel, .ioAddr, .ptrWrite, .ptrLowAddr, .ptrValue, .ptrY);

// file: bench/data_space_far_model.sv
// register file and io banks that sit behind the decoder
`timescale 1ns/1ns
module data_space_far_model (
    input wire logic         ref_clk,
    input wire logic [4:0]   regAddr,
    input wire logic         regWrite,
    input wire logic [7:0]   regWdata,
    output logic [7:0]       regRdata,
    input wire logic         ptrWrite,
    input wire logic [4:0]   ptrLowAddr,
    input wire logic [15:0]  ptrValue,
    output logic [15:0]      ptrX,
    output logic [15:0]      ptrY,
    output logic [15:0]      ptrZ,
    input wire logic         stdIoSel,
    input wire logic         extIoSel,
    input wire logic [7:0]   ioAddr,
    input wire logic         ioWrite,
    input wire logic [7:0]   ioWdata,
    output logic [7:0]       ioRdata
);
    logic [7:0] regs[0:31] = '{default: 8'h00};
    logic [7:0] io[0:255] = '{default: 8'h00};
    // pointers are plain register pairs, low byte first
    assign ptrX = {regs[27], regs[26]};
    assign ptrY = {regs[29], regs[28]};
    assign ptrZ = {regs[31], regs[30]};
    assign regRdata = regs[regAddr];
    // unselected bank shows a flipped value so a stale read is caught
    assign ioRdata = (stdIoSel || extIoSel) ? io[ioAddr] : ~io[ioAddr];
    // writes land on the edge that takes the request
    always @(posedge ref_clk) begin
        if (regWrite)
            regs[regAddr] <= regWdata;
        if (ptrWrite)
            {regs[ptrLowAddr + 5'h01], regs[ptrLowAddr]} <= ptrValue;
        if (ioWrite && (stdIoSel || extIoSel))
            io[ioAddr] <= ioWdata;
    end
endmodule

// file: bench/data_space_decoder_tb.sv
// self-checking bench for the data space decoder
`timescale 1ns/1ns
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module data_space_decoder_tb;
    logic ref_clk, rst, busy, regWrite, ptrWrite, stdIoSel, extIoSel, ioWrite, progHighByte;
    logic progInRange, selfProgramAllowed, nvdataInRange;
    logic [4:0] regAddr, ptrLowAddr;
    logic [7:0] regWdata, regRdata, ioAddr, ioWdata, ioRdata;
    logic [15:0] ptrValue, ptrX, ptrY, ptrZ, progByteAddr, nvdataAddr;
    logic [12:0] progWordAddr;
    data_space_pkg::data_req_t req;
    data_space_pkg::data_rsp_t rsp;
    logic [7:0] mem[0:767];
    logic [31:0] seed = 32'h0000_777b;
    int fails = 0;
    int nTests = 0;

    data_space_decoder dut (.ref_clk, .rst, .req, .rsp, .busy, .regAddr, .regWrite, .regWdata,
        .regRdata, .ptrWrite, .ptrLowAddr, .ptrValue, .ptrX, .ptrY, .ptrZ, .stdIoSel, .extIoSel,
        .ioAddr, .ioWrite, .ioWdata, .ioRdata, .progByteAddr, .progWordAddr, .progHighByte,
        .progInRange, .selfProgramAllowed, .nvdataAddr, .nvdataInRange);
    data_space_far_model far (.ref_clk, .regAddr, .regWrite, .regWdata, .regRdata, .ptrWrite,
        .ptrLowAddr, .ptrValue, .ptrX, .ptrY, .ptrZ, .stdIoSel, .extIoSel, .ioAddr, .ioWrite,
        .ioWdata, .ioRdata);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one access: model first, then drive, hold through busy, check answer
    task automatic op(input logic wr, input logic sio, input int md, input int pt,
                      input logic [15:0] ad, input logic [5:0] dp, input logic [7:0] wd);
        int lo, p, ea, k;
        logic refd;
        logic [7:0] exp;
        lo = 26 + 2 * pt;
        p = {mem[lo + 1], mem[lo]};
        // displacement sum wraps at 16 bits like the pointer itself
        ea = sio ? 32 + ad[5:0] : md == 0 ? ad : md == 1 ? (p + dp) % 65536
           : md == 3 ? (p + 65535) % 65536 : p;
        refd = ea > 767 || (!sio && md == 1 && pt == 0);
        // read sees old contents; pointer writeback wins over a data write to it
        exp = refd ? 8'h00 : mem[ea];
        if (wr && !refd)
            mem[ea] = wd;
        if (!sio && md == 3)
            {mem[lo + 1], mem[lo]} = 16'(ea);
        if (!sio && md == 4)
            {mem[lo + 1], mem[lo]} = 16'(p + 1);
        @(negedge ref_clk);
        req = '{1'b1, wr, sio, data_space_pkg::addr_mode_t'(3'(md)),
                data_space_pkg::ptr_sel_t'(2'(pt)), ad, dp, wd};
        progByteAddr = 16'(rnd());
        nvdataAddr = 16'(rnd());
        @(posedge ref_clk);
        #1;
        for (k = 0; k < 4 && busy === 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(progWordAddr, progByteAddr[13:1])
        `CHK({progHighByte, progInRange}, {progByteAddr[0], progByteAddr <= 16'h3FFF})
        `CHK({selfProgramAllowed, nvdataInRange}, {1'b1, nvdataAddr <= 16'h01FF})
        @(negedge ref_clk);
        req.valid = 1'b0;
        for (k = 0; k < 4 && rsp.done !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK({rsp.done, rsp.refused}, {1'b1, refd})
        if (!wr)
            `CHK(rsp.rdata, exp)
    endtask

    // free-running core clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // cut a hang short well past the expected run length
    initial begin
        #(4 * 40000);
        fails++;
        test_done();
    end

    // fill whole space, read it all back past the top, then random traffic
    initial begin
        logic [31:0] r;
        logic [15:0] a;
        rst = 1'b1;
        req = '0;
        progByteAddr = 16'h0000;
        nvdataAddr = 16'h0000;
        foreach (mem[i])
            mem[i] = 8'h00;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 768; i++)
            op(1, 0, 0, 0, 16'(i), 0, i inside {27, 29, 31} ? 8'(i % 3) : 8'(rnd()));
        for (int i = 0; i < 784; i++)
            op(0, 0, 0, 0, 16'(i), 0, 8'h00);
        $display("test map done");
        for (int i = 0; i < 1500; i++) begin
            r = rnd();
            a = 16'(r[31:16] % 800);
            op(r[8], r[0] & r[1], (r[0] & r[1]) ? 0 : r[4:2] % 5, r[6:5] % 3, a, r[14:9],
               a inside {27, 29, 31} ? 8'(r[22:17] % 3) : 8'(rnd()));
        end
        $display("test random done");
        test_done();
    end
endmodule
